// ==== hdl/pss_pkg.sv ====
package pss_pkg;

    // ----------------
    // Register map
    // ----------------
    localparam logic [7:0] REG_CTRL_ADDR   = 8'h00;
    localparam logic [7:0] REG_MUTE_ADDR   = 8'h04;
    localparam logic [7:0] REG_STATUS_ADDR = 8'h08;

    // Control register fields.
    localparam int CTRL_POLICY_LSB  = 0;
    localparam int CTRL_START_EN    = 3;
    localparam int CTRL_GUARD_EN    = 4;
    localparam int CTRL_RUNMODE_LSB = 6;
    localparam int CTRL_MUTEMODE_LSB = 8;
    localparam int CTRL_LONG_CLEAR  = 10;
    localparam int CTRL_ZONE_DESEL  = 11;

    // Status register fields.
    localparam int STAT_ENABLE   = 0;
    localparam int STAT_PENDING  = 1;
    localparam int STAT_ARMED    = 2;
    localparam int STAT_MUTING   = 3;
    localparam int STAT_MUTE_END = 4;

    // ----------------
    // Configuration encodings and reset values
    // ----------------
    localparam logic [2:0] POLICY_NONE    = 3'h1;
    localparam logic [2:0] POLICY_ALWAYS  = 3'h2;
    localparam logic [2:0] POLICY_RUN     = 3'h3;
    localparam logic [2:0] POLICY_STROKE  = 3'h4;
    localparam logic [2:0] POLICY_PERMIT  = 3'h5;
    localparam logic [1:0] RUN_INCHING    = 2'h1;
    localparam logic [1:0] RUN_SINGLE     = 2'h2;
    localparam logic [1:0] MUTE_NONE      = 2'h1;
    localparam logic [1:0] MUTE_GUARD     = 2'h2;
    localparam logic [1:0] MUTE_GUARD_RUN = 2'h3;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0142;
    localparam logic [15:0] MUTE_RESET = 16'h0001;

    // ----------------
    // Timing
    // ----------------
    localparam int CLK_PERIOD_NS  = 50;
    localparam int MS_PERIOD_NS   = 1_000_000;
    localparam int MS_CYCLES      = MS_PERIOD_NS / CLK_PERIOD_NS;
    localparam int MS_PER_SEC     = 1000;
    localparam int CLEAR_MIN_SHORT_MS = 100;
    localparam int CLEAR_MIN_LONG_MS  = 350;
    localparam int CLEAR_MAX_S        = 30;
    localparam int CLEAR_MAX_MS       = CLEAR_MAX_S * MS_PER_SEC;
    localparam int MUTE_MAX_S         = 7200;

    typedef enum logic [1:0] {
        MUTE_IDLE,
        MUTE_ON,
        MUTE_OVER
    } pss_mute_t;

endpackage

// ==== hdl/pss_tick_if.sv ====
interface pss_tick_if;
    logic msTick;
    logic secTick;

    modport src (output msTick, output secTick);
    modport snk (input msTick, input secTick);
endinterface

// ==== hdl/pss_tick_gen.sv ====
module pss_tick_gen #(
    parameter int MS_CYCLES = pss_pkg::MS_CYCLES
) (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rstN,
    // Tick outputs
    pss_tick_if.src    ticks
);
    import pss_pkg::*;

    localparam int CW = $clog2(MS_CYCLES);
    localparam int SW = $clog2(MS_PER_SEC);

    if (MS_CYCLES < 2) begin : g_bad_ms
        $error("MS_CYCLES must be at least 2");
    end

    logic [CW-1:0] cycCnt_q;
    logic [SW-1:0] msCnt_q;
    logic          msTick_q;
    logic          secTick_q;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cycCnt_q <= '0;
            msTick_q <= 1'b0;
        end else if (cycCnt_q == CW'(MS_CYCLES - 1)) begin
            cycCnt_q <= '0;
            msTick_q <= 1'b1;
        end else begin
            cycCnt_q <= cycCnt_q + 1'b1;
            msTick_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            msCnt_q   <= '0;
            secTick_q <= 1'b0;
        end else begin
            secTick_q <= 1'b0;
            if (msTick_q) begin
                if (msCnt_q == SW'(MS_PER_SEC - 1)) begin
                    msCnt_q   <= '0;
                    secTick_q <= 1'b1;
                end else begin
                    msCnt_q <= msCnt_q + 1'b1;
                end
            end
        end
    end

    assign ticks.msTick  = msTick_q;
    assign ticks.secTick = secTick_q;
endmodule

// ==== hdl/pss_pulse_check.sv ====
module pss_pulse_check (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rstN,
    // Time base
    pss_tick_if.snk    ticks,
    // Pulse input and setting
    input  wire logic  level,
    input  wire logic  levelPrev,
    input  wire logic  longMin,
    // Result
    output logic       pulseOk
);
    import pss_pkg::*;

    localparam int HW = 15;
    localparam logic [HW-1:0] MIN_SHORT = HW'(CLEAR_MIN_SHORT_MS);
    localparam logic [HW-1:0] MIN_LONG  = HW'(CLEAR_MIN_LONG_MS);
    localparam logic [HW-1:0] MAX_HIGH  = HW'(CLEAR_MAX_MS);

    logic [HW-1:0] highMs_q;
    logic          pulseOk_q;
    logic [HW-1:0] minMs;

    assign minMs = longMin ? MIN_LONG : MIN_SHORT;

    // The counter saturates, so a stuck-high input can never wrap round
    // into the accepted window.
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            highMs_q <= '0;
        end else if (level && !levelPrev) begin
            highMs_q <= '0;
        end else if (level && ticks.msTick && highMs_q != '1) begin
            highMs_q <= highMs_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pulseOk_q <= 1'b0;
        end else begin
            pulseOk_q <= !level && levelPrev && highMs_q >= minMs && highMs_q <= MAX_HIGH;
        end
    end

    assign pulseOk = pulseOk_q;
endmodule

// ==== hdl/pss_single_stroke.sv ====
// Operation
// - Restart-needed output shows armed interlock only while all active permits are high.
// - Policy 1 never arms; a new run rising edge resumes after any stop.
// - Policy 2 starts armed and re-arms on every kind of stop.
// - Policy 3 re-arms on run, main or guard permit falling.
// - Policy 4 re-arms on stroke end rising or main or guard falling.
// - Policy 5 re-arms only on main or guard permit falling.
// - With deselect on, guard low at stroke end does not arm.
// - Start and guard permits count only when their enable settings are on.
// - Inching stops on run falling; single start ignores run falling once started.
// - Run rising edge starts; run low stops except in single start.
// - Mute mode 1 ignores the upstroke contact and never mutes.
// - Mute mode 2 lets guard go low in the window without effect.
// - Mute mode 3 also ignores run low while upstroke contact stays high.
// - Mute timer of 1 to 7200 s starts on upstroke contact rising; the code does not limit it and takes any low 13-bit value, 0 included.
// - After timer expiry any muted input low drops the enable.
// - Clear is a low-high-low pulse with high at least 100 or 350 ms.
// - Main permit low forces the enable low at once.
// - Stroke end rising always forces the enable low.
// - Clear pulses shorter than minimum or longer than 30 s are ignored.
// - Enable rises on run rising edge only if not armed and permits high.
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
module pss_single_stroke #(
    parameter int AXI_ADDR_W = 8,
    parameter int MS_CYCLES  = pss_pkg::MS_CYCLES
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    // AXI4-Lite write address
    input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Press inputs
    input  wire logic                  run_request,
    input  wire logic                  main_permit,
    input  wire logic                  start_permit,
    input  wire logic                  guard_permit,
    input  wire logic                  stroke_end_position,
    input  wire logic                  upstroke_contact,
    input  wire logic                  interlock_clear_input,
    // Press outputs
    output logic                       press_enable,
    output logic                       reset_pending
);
    import pss_pkg::*;

    if (AXI_ADDR_W < 4) begin : g_bad_addr
        $error("AXI_ADDR_W must be at least 4");
    end

    // ----------------
    // Reset release
    // ----------------
    logic [1:0] rstSync_q;
    logic       rstN;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync_q <= 2'b00;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstN = rstSync_q[1];

    // ----------------
    // Register bus
    // ----------------
    logic [31:0] ctrl_q;
    logic [15:0] muteSec_q;
    logic [31:0] status;
    logic [7:0]  awAddr_q;
    logic        awHeld_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        wHeld_q;
    logic        bValid_q;
    logic [1:0]  bResp_q;
    logic        rValid_q;
    logic [31:0] rData_q;
    logic [1:0]  rResp_q;
    logic        doWrite;

    assign s_axi_awready = !awHeld_q && !bValid_q;
    assign s_axi_wready  = !wHeld_q && !bValid_q;
    assign s_axi_arready = !rValid_q;
    assign s_axi_bvalid  = bValid_q;
    assign s_axi_bresp   = bResp_q;
    assign s_axi_rvalid  = rValid_q;
    assign s_axi_rdata   = rData_q;
    assign s_axi_rresp   = rResp_q;
    assign doWrite       = awHeld_q && wHeld_q && !bValid_q;

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            awHeld_q <= 1'b0;
            awAddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= {(|s_axi_awaddr[AXI_ADDR_W-1:4]) ? 4'hF : 4'h0,
                         s_axi_awaddr[3:2], 2'b00};
        end else if (doWrite) begin
            awHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            wHeld_q <= 1'b0;
            wData_q <= '0;
            wStrb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld_q <= 1'b0;
        end
    end

    // Configuration is taken byte by byte; unmapped writes answer SLVERR.
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            ctrl_q    <= CTRL_RESET;
            muteSec_q <= MUTE_RESET;
            bValid_q  <= 1'b0;
            bResp_q   <= 2'b00;
        end else if (doWrite) begin
            bValid_q <= 1'b1;
            bResp_q  <= 2'b00;
            if (awAddr_q == REG_CTRL_ADDR) begin
                for (int i = 0; i < 4; i++) begin
                    if (wStrb_q[i]) begin
                        ctrl_q[i*8 +: 8] <= wData_q[i*8 +: 8];
                    end
                end
            end else if (awAddr_q == REG_MUTE_ADDR) begin
                for (int i = 0; i < 2; i++) begin
                    if (wStrb_q[i]) begin
                        muteSec_q[i*8 +: 8] <= wData_q[i*8 +: 8];
                    end
                end
            end else if (awAddr_q != REG_STATUS_ADDR) begin
                bResp_q <= 2'b10;
            end
        end else if (bValid_q && s_axi_bready) begin
            bValid_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            rValid_q <= 1'b0;
            rData_q  <= '0;
            rResp_q  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rValid_q <= 1'b1;
            rResp_q  <= 2'b00;
            rData_q  <= '0;
            if (|s_axi_araddr[AXI_ADDR_W-1:4]) begin
                rResp_q <= 2'b10;
            end else if ({4'h0, s_axi_araddr[3:2], 2'b00} == REG_CTRL_ADDR) begin
                rData_q <= {20'h0_0000, ctrl_q[11:8], ctrl_q[7:6], 1'b0, ctrl_q[4:0]};
            end else if ({4'h0, s_axi_araddr[3:2], 2'b00} == REG_MUTE_ADDR) begin
                rData_q <= {16'h0000, muteSec_q};
            end else if ({4'h0, s_axi_araddr[3:2], 2'b00} == REG_STATUS_ADDR) begin
                rData_q <= status;
            end else begin
                rResp_q <= 2'b10;
            end
        end else if (rValid_q && s_axi_rready) begin
            rValid_q <= 1'b0;
        end
    end

    // ----------------
    // Configuration decode
    // ----------------
    // Illegal codes fall back to the safest setting of each field.
    logic [2:0] policy;
    logic [1:0] muteMode;
    logic       runSingle;
    logic       startEn;
    logic       guardEn;
    logic       zoneDesel;
    logic       longClear;

    always_comb begin
        policy = ctrl_q[CTRL_POLICY_LSB +: 3];
        if (policy < POLICY_NONE || policy > POLICY_PERMIT) begin
            policy = POLICY_ALWAYS;
        end
        muteMode = ctrl_q[CTRL_MUTEMODE_LSB +: 2];
        if (muteMode != MUTE_GUARD && muteMode != MUTE_GUARD_RUN) begin
            muteMode = MUTE_NONE;
        end
    end
    assign runSingle = ctrl_q[CTRL_RUNMODE_LSB +: 2] == RUN_SINGLE;
    assign startEn   = ctrl_q[CTRL_START_EN];
    assign guardEn   = ctrl_q[CTRL_GUARD_EN];
    assign zoneDesel = ctrl_q[CTRL_ZONE_DESEL];
    assign longClear = ctrl_q[CTRL_LONG_CLEAR];

    // ----------------
    // Input sampling and edges
    // ----------------
    logic [6:0] in_q;
    logic [6:0] inPrev_q;

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            in_q     <= '0;
            inPrev_q <= '0;
        end else begin
            in_q     <= {interlock_clear_input, upstroke_contact, stroke_end_position,
                         guard_permit, start_permit, main_permit, run_request};
            inPrev_q <= in_q;
        end
    end

    logic runQ, mainQ, startQ, guardQ, strokeQ, upQ, clearQ;
    assign {clearQ, upQ, strokeQ, guardQ, startQ, mainQ, runQ} = in_q;

    logic runRise, runFall, mainFall, guardFall, strokeRise, upRise, upFall;
    assign runRise    = runQ && !inPrev_q[0];
    assign runFall    = !runQ && inPrev_q[0];
    assign mainFall   = !mainQ && inPrev_q[1];
    assign guardFall  = guardEn && !guardQ && inPrev_q[3];
    assign strokeRise = strokeQ && !inPrev_q[4];
    assign upRise     = upQ && !inPrev_q[5];
    assign upFall     = !upQ && inPrev_q[5];

    logic startOk, guardOk;
    assign startOk = !startEn || startQ;
    assign guardOk = !guardEn || guardQ;

    // ----------------
    // Time base and clear pulse check
    // ----------------
    pss_tick_if ticks ();
    logic clearOk;

    pss_tick_gen #(
        .MS_CYCLES (MS_CYCLES)
    ) u_tick (
        .clk   (sys_clk),
        .rstN  (rstN),
        .ticks (ticks)
    );

    pss_pulse_check u_clear (
        .clk       (sys_clk),
        .rstN      (rstN),
        .ticks     (ticks),
        .level     (clearQ),
        .levelPrev (inPrev_q[6]),
        .longMin   (longClear),
        .pulseOk   (clearOk)
    );

    // ----------------
    // Upstroke muting
    // ----------------
    pss_mute_t   mute_q;
    logic [12:0] muteCnt_q;
    logic        enable_q;

    // Muting only opens while the press is running with main permit high,
    // so an upstroke contact cannot bypass anything at standstill.
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            mute_q    <= MUTE_IDLE;
            muteCnt_q <= '0;
        end else begin
            unique case (mute_q)
                MUTE_IDLE: begin
                    if (muteMode != MUTE_NONE && upRise && enable_q && mainQ) begin
                        mute_q    <= MUTE_ON;
                        muteCnt_q <= '0;
                    end
                end
                MUTE_ON: begin
                    if (upFall || !enable_q) begin
                        mute_q <= MUTE_IDLE;
                    end else if (muteCnt_q >= muteSec_q[12:0]) begin
                        mute_q <= MUTE_OVER;
                    end else if (ticks.secTick) begin
                        muteCnt_q <= muteCnt_q + 1'b1;
                    end
                end
                MUTE_OVER: begin
                    if (!upQ) begin
                        mute_q <= MUTE_IDLE;
                    end
                end
            endcase
        end
    end

    logic muteGuard, muteRun;
    assign muteGuard = mute_q == MUTE_ON;
    assign muteRun   = mute_q == MUTE_ON && muteMode == MUTE_GUARD_RUN;

    // ----------------
    // Stroke control and interlock
    // ----------------
    logic guardDrop, runStop, stopNow, startNow;
    logic armMain, armGuard, armRun, armStroke, armSet;
    logic armed_q, pending_q;

    assign guardDrop = guardEn && !guardQ && !muteGuard;
    assign runStop   = !runSingle && !runQ && !muteRun;
    assign stopNow   = !mainQ || strokeRise || guardDrop || runStop;
    assign startNow  = runRise && !armed_q && mainQ && startOk && guardOk;

    assign armMain   = mainFall || (enable_q && !mainQ);
    assign armGuard  = (guardFall && !muteGuard || enable_q && guardDrop)
                       && !(zoneDesel && strokeQ);
    assign armRun    = enable_q && runStop;
    assign armStroke = enable_q && strokeRise;

    always_comb begin
        unique case (policy)
            POLICY_ALWAYS: armSet = armMain || armGuard || armRun || armStroke;
            POLICY_RUN:    armSet = armMain || armGuard || armRun;
            POLICY_STROKE: armSet = armMain || armGuard || armStroke;
            POLICY_PERMIT: armSet = armMain || armGuard;
            default:       armSet = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            enable_q <= 1'b0;
        end else if (stopNow) begin
            enable_q <= 1'b0;
        end else if (!enable_q && startNow) begin
            enable_q <= 1'b1;
        end
    end

    // A fresh stop outranks a clear that lands in the same cycle.
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            armed_q <= 1'b1;
        end else if (policy == POLICY_NONE) begin
            armed_q <= 1'b0;
        end else if (armSet) begin
            armed_q <= 1'b1;
        end else if (clearOk && !enable_q) begin
            armed_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            pending_q <= 1'b0;
        end else begin
            pending_q <= armed_q && policy != POLICY_NONE && mainQ && startOk && guardOk;
        end
    end

    // Main permit is gated again here so the enable falls in the same cycle
    // as the sampled permit, not one later.
    assign press_enable  = enable_q && mainQ;
    assign reset_pending = pending_q;

    assign status = {27'h000_0000, mute_q == MUTE_OVER, muteGuard, armed_q,
                     pending_q, press_enable};
endmodule

// ==== bench/pss_single_stroke_checker.sv ====
module pss_single_stroke_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Bus handshakes
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Press signals
    input wire logic run_request,
    input wire logic main_permit,
    input wire logic stroke_end_position,
    input wire logic press_enable,
    input wire logic reset_pending
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    main_low_a: assert property (!main_permit |=> !press_enable)
        else $error("enable stayed high with main permit low");
    pend_main_a: assert property (!main_permit [*4] |-> !reset_pending)
        else $error("restart request shown without main permit");
    pend_excl_a: assert property (reset_pending |-> !press_enable)
        else $error("enable high while restart pending");
    stroke_end_a: assert property ($rose(stroke_end_position) |-> ##3 !press_enable)
        else $error("enable kept after stroke end");
    start_edge_a: assert property ($rose(press_enable) |->
        $past(run_request) && !$past(run_request, 4)) else $error("enable without run edge");
    start_main_a: assert property ($rose(press_enable) |-> $past(main_permit, 2))
        else $error("enable rose without main permit");
    reset_low_a: assert property ($rose(reset_n) |-> !press_enable [*3])
        else $error("enable high after reset");
    bus_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");

    en_c: cover property ($rose(press_enable));
    pend_c: cover property ($rose(reset_pending));
    stop_c: cover property ($fell(press_enable) && main_permit);
endmodule

// ==== bench/pss_press_model.sv ====
module pss_press_model #(
    parameter int STROKE = 40
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Press contacts
    input wire logic press_enable,
    output logic     stroke_end_position,
    output logic     upstroke_contact
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] posQ;

    // The ram advances only while enabled and returns to zero from stroke end, so a dropped enable parks it mid-stroke.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) posQ <= 8'h00;
        else if (press_enable) posQ <= posQ + 8'h01;
        else if (posQ >= 8'(STROKE)) posQ <= 8'h00;
    end

    assign stroke_end_position = (posQ == 8'h00) || (posQ >= 8'(STROKE));
    assign upstroke_contact = (posQ != 8'h00) && (posQ < 8'h08);
endmodule

// ==== bench/pss_single_stroke_tb.sv ====
module pss_single_stroke_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pss_pkg::*;
    localparam int MS = 4;
    typedef struct packed { logic [2:0] pol; logic arm; } pss_row_t;
    logic        sys_clk, reset_n, run_request, main_permit, start_permit, guard_permit;
    logic        interlock_clear_input, stroke_end_position, upstroke_contact;
    logic        press_enable, reset_pending, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, q;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    int          nFail, checksDone, cyc;
    pss_row_t    rows [5] = '{'{3'h1, 1'b0}, '{3'h2, 1'b1}, '{3'h3, 1'b0},
                              '{3'h4, 1'b1}, '{3'h5, 1'b0}};

    pss_single_stroke #(.MS_CYCLES(MS)) u_dut (.sys_clk, .reset_n, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .run_request, .main_permit, .start_permit, .guard_permit,
        .stroke_end_position, .upstroke_contact, .interlock_clear_input, .press_enable,
        .reset_pending);
    pss_press_model u_press (.sys_clk, .reset_n, .press_enable, .stroke_end_position,
        .upstroke_contact);

    task automatic closeOut();
        $display("checks %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            nFail++;
            $display("mismatch at %0t: word %h want %h", $time, got, exp);
        end
    endtask

    task automatic checkBit(input logic got, input logic exp);
        checkWord({31'h0, got}, {31'h0, exp});
    endtask

    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, ka, kw;
        @(posedge sys_clk);
        ta = 1'b1;
        tw = wr;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_arvalid <= !wr;
        s_axi_bready <= wr;
        s_axi_rready <= !wr;
        while (ta || tw) begin
            @(negedge sys_clk);
            ka = ta && (wr ? s_axi_awready : s_axi_arready);
            kw = tw && s_axi_wready;
            @(posedge sys_clk);
            if (ka) ta = 1'b0;
            if (kw) tw = 1'b0;
            if (ka) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
            if (kw) s_axi_wvalid <= 1'b0;
        end
        do @(negedge sys_clk); while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
        q = s_axi_rdata;
        r = wr ? s_axi_bresp : s_axi_rresp;
        @(posedge sys_clk);
        {s_axi_bready, s_axi_rready} <= 2'h0;
    endtask

    // The clearing party's pulse; the tail gives the design time to act on it.
    task automatic clr(input int ms);
        @(posedge sys_clk);
        interlock_clear_input <= 1'b1;
        repeat (ms * MS) @(posedge sys_clk);
        interlock_clear_input <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic go(input logic exp);
        @(posedge sys_clk);
        run_request <= 1'b1;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        checkBit(press_enable, exp);
    endtask

    task automatic pause(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic drop();
        @(posedge sys_clk);
        run_request <= 1'b0;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            nFail++;
            closeOut();
        end
    end

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {run_request, interlock_clear_input, reset_n, s_axi_awaddr, s_axi_araddr} = '0;
        {main_permit, start_permit, guard_permit, s_axi_wstrb} = '1;
        s_axi_wdata = '0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        pause(4);
        checkBit(press_enable, 1'b0);
        axi(0, REG_CTRL_ADDR, '0);
        checkWord(q, CTRL_RESET);
        axi(0, REG_MUTE_ADDR, '0);
        checkWord(q, {16'h0000, MUTE_RESET});
        axi(0, REG_STATUS_ADDR, '0);
        checkBit(q[STAT_ARMED], 1'b1);
        axi(0, 8'h0C, '0);
        checkWord({30'h0, r}, 32'h0000_0002);
        foreach (rows[i]) begin
            axi(1, REG_CTRL_ADDR, 32'h0000_0140 | 32'(rows[i].pol));
            clr(150);
            go(1'b1);
            pause(60);
            checkBit(press_enable, 1'b0);
            axi(0, REG_STATUS_ADDR, '0);
            checkBit(q[STAT_ARMED], rows[i].arm);
            checkBit(reset_pending, rows[i].arm);
            drop();
        end
        axi(1, REG_CTRL_ADDR, 32'h0000_0142);
        clr(150);
        go(1'b1);
        drop();
        pause(4);
        checkBit(press_enable, 1'b0);
        clr(50);
        go(1'b0);
        drop();
        clr(150);
        go(1'b1);
        @(posedge sys_clk);
        main_permit <= 1'b0;
        pause(2);
        checkBit(press_enable, 1'b0);
        pause(3);
        checkBit(reset_pending, 1'b0);
        @(posedge sys_clk);
        main_permit <= 1'b1;
        pause(4);
        checkBit(reset_pending, 1'b1);
        drop();
        axi(1, REG_CTRL_ADDR, 32'h0000_0181);
        go(1'b1);
        drop();
        pause(4);
        checkBit(press_enable, 1'b1);
        pause(60);
        checkBit(press_enable, 1'b0);
        closeOut();
    end
endmodule

bind pss_single_stroke pss_single_stroke_checker u_chk (.sys_clk, .reset_n, .s_axi_bvalid,
    .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .run_request, .main_permit,
    .stroke_end_position, .press_enable, .reset_pending);
